// ===== adcsw_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module adcsw_bench;
    logic i_mclk;
    logic i_rst_n;
    logic [9:0] i_avs_address;
    logic i_avs_read;
    logic i_avs_write;
    logic [31:0] i_avs_writedata;
    logic [3:0] i_avs_byteenable;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [7:0] i_tmr_ovf;
    logic i_external_start_pin;
    logic [9:0] i_sample;
    logic o_irq;
    int n_fail;
    int total_checks;
    int seed;
    logic [7:0] v;
    logic [15:0] gt;
    logic [15:0] lt;
    logic [15:0] w;
    logic [2:0] sel;
    logic [1:0] m;
    logic lj;
    logic hit;
    adcsw_top u_adcsw_top (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_tmr_ovf(i_tmr_ovf),
        .i_external_start_pin(i_external_start_pin),
        .i_sample(i_sample),
        .o_irq(o_irq)
    );
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // ****
    // bus and trigger tasks
    // ****
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_avs_address <= {a, 2'h0};
        i_avs_writedata <= {24'h00_0000, d};
        i_avs_write <= 1'b1;
        @(posedge i_mclk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_mclk);
        i_avs_write <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        i_avs_address <= {a, 2'h0};
        i_avs_read <= 1'b1;
        @(posedge i_mclk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_mclk);
        v = o_avs_readdata[7:0];
        i_avs_read <= 1'b0;
        @(posedge i_mclk);
        if (a != adcsw_pkg::IDX_CTRL || e[4] == 1'b0) `CHK(v, e)
    endtask
    // one-cycle pulse; extra edges let the edge detector and start land
    task automatic trig(input logic [7:0] t, input logic p);
        i_tmr_ovf <= t;
        i_external_start_pin <= p;
        @(posedge i_mclk);
        i_tmr_ovf <= 8'h00;
        i_external_start_pin <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask
    // trigger to done interrupt, edges counted; tracking adds its delay
    task automatic lat(input logic td, input logic [2:0] s, input int e);
        int n;
        wr(adcsw_pkg::IDX_IRQ_MASK, 8'h01);
        wr(adcsw_pkg::IDX_CTRL, {1'b1, td, 3'h0, s});
        i_tmr_ovf <= (s == 3'h4) ? 8'h00 : 8'h01 << s;
        i_external_start_pin <= (s == 3'h4);
        @(posedge i_mclk);
        i_tmr_ovf <= 8'h00;
        i_external_start_pin <= 1'b0;
        n = 1;
        while (o_irq !== 1'b1 && n < 100) begin
            @(posedge i_mclk);
            n++;
        end
        `CHK(n, e)
    endtask
    function automatic logic hitf(logic [15:0] x, logic [15:0] g, logic [15:0] l);
        return (l > g) ? (x > g && x < l) : (x > g || x < l);
    endfunction
    task automatic complete_run();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        complete_run();
    end
    initial begin
        seed = 99928;
        n_fail = 0;
        total_checks = 0;
        i_rst_n = 1'b0;
        i_avs_address = 10'h000;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0000_0000;
        i_avs_byteenable = 4'hF;
        i_tmr_ovf = 8'h00;
        i_external_start_pin = 1'b0;
        i_sample = 10'h000;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        chk_rd(adcsw_pkg::IDX_GT_HIGH, 8'hFF);
        chk_rd(adcsw_pkg::IDX_GT_LOW, 8'hFF);
        chk_rd(adcsw_pkg::IDX_LT_HIGH, 8'h00);
        chk_rd(adcsw_pkg::IDX_LT_LOW, 8'h00);
        chk_rd(adcsw_pkg::IDX_CTRL, 8'h00);
        chk_rd(adcsw_pkg::IDX_IRQ_STAT, 8'h00);
        chk_rd(8'h10, 8'h00);
        i_avs_byteenable <= 4'h0;
        wr(adcsw_pkg::IDX_GT_HIGH, 8'h12);
        i_avs_byteenable <= 4'hF;
        chk_rd(adcsw_pkg::IDX_GT_HIGH, 8'hFF);
        wr(adcsw_pkg::IDX_GT_HIGH, 8'hA5);
        chk_rd(adcsw_pkg::IDX_GT_HIGH, 8'hA5);
        wr(adcsw_pkg::IDX_RES_HIGH, 8'h5A);
        chk_rd(adcsw_pkg::IDX_RES_HIGH, 8'h00);
        for (int i = 0; i < 24; i++) begin
            sel = i[2:0];
            lj = (i < 8) ? 1'b0 : 1'($random(seed));
            gt = (i < 8) ? (i[0] ? 16'h0040 : 16'h0080) : 16'($random(seed));
            lt = (i < 8) ? (i[0] ? 16'h0080 : 16'h0040) : 16'($random(seed));
            i_sample <= (i < 8) ? 10'h03F + 10'(i[2:1]) : 10'($random(seed));
            m = 2'($random(seed));
            wr(adcsw_pkg::IDX_CFG, {7'h00, lj});
            wr(adcsw_pkg::IDX_GT_HIGH, gt[15:8]);
            wr(adcsw_pkg::IDX_GT_LOW, gt[7:0]);
            wr(adcsw_pkg::IDX_LT_HIGH, lt[15:8]);
            wr(adcsw_pkg::IDX_LT_LOW, lt[7:0]);
            wr(adcsw_pkg::IDX_IRQ_MASK, {6'h00, m});
            wr(adcsw_pkg::IDX_CTRL, {5'h10, sel});
            wr(adcsw_pkg::IDX_CTRL, {5'h12, sel});
            if (sel != 3'h0) begin
                chk_rd(adcsw_pkg::IDX_CTRL, {5'h10, sel});
                trig(8'h01 << 3'(sel + 3'h1), sel != 3'h4);
                chk_rd(adcsw_pkg::IDX_CTRL, {5'h10, sel});
                trig((sel == 3'h4) ? 8'h00 : 8'h01 << sel, sel == 3'h4);
            end
            chk_rd(adcsw_pkg::IDX_CTRL, {5'h12, sel});
            `CHK(v[4], 1'b1)
            for (int k = 0; k < 20 && v[4]; k++) chk_rd(adcsw_pkg::IDX_CTRL, 8'h10);
            w = lj ? {i_sample, 6'h00} : {6'h00, i_sample};
            hit = hitf(w, gt, lt);
            `CHK(v, {3'h5, 1'b0, hit, sel})
            chk_rd(adcsw_pkg::IDX_RES_HIGH, w[15:8]);
            chk_rd(adcsw_pkg::IDX_RES_LOW, w[7:0]);
            chk_rd(adcsw_pkg::IDX_IRQ_STAT, {6'h00, hit, 1'b1});
            `CHK(o_irq, |({hit, 1'b1} & m))
            if (i[3]) begin
                wr(adcsw_pkg::IDX_IRQ_STAT, 8'h03);
            end else begin
                wr(adcsw_pkg::IDX_CTRL, {5'h10, sel});
            end
            chk_rd(adcsw_pkg::IDX_CTRL, {5'h10, sel});
            `CHK(o_irq, 1'b0)
        end
        lat(1'b0, 3'h1, adcsw_pkg::CONV_CYCLES + 2);
        lat(1'b1, 3'h1, adcsw_pkg::CONV_CYCLES + adcsw_pkg::TRACK_CYCLES + 2);
        lat(1'b1, 3'h4, adcsw_pkg::CONV_CYCLES + 2);
        complete_run();
    end
endmodule

// ===== adcsw_checker.sv
`timescale 1ns/1ps
module adcsw_checker (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq
);
    logic req;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] idx;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    assign req = i_avs_read | i_avs_write;
    assign idx = i_avs_address[9:2];
    assign wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
    assign rd_ok = i_avs_read & ~o_avs_waitrequest;
    // ****
    // shadows of software-owned fields
    // ****
    always_comb begin
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        if (wr_ok && idx == adcsw_pkg::IDX_IRQ_MASK) begin
            mask_d = i_avs_writedata[1:0];
        end
        if (wr_ok && idx == adcsw_pkg::IDX_CTRL) begin
            ctrl_d = i_avs_writedata[7:0];
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mask_q <= 2'h0;
            ctrl_q <= 8'h00;
        end else begin
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_idle; !req |-> !o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    property p_first; req && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
    a_first: assert property (p_first) else $error("access not done");
    property p_two; req && !o_avs_waitrequest |-> $past(o_avs_waitrequest); endproperty
    a_two: assert property (p_two) else $error("access too short");
    property p_hi; o_avs_readdata[31:8] == 24'h00_0000; endproperty
    a_hi: assert property (p_hi) else $error("upper lanes set");
    property p_stable; !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata); endproperty
    a_stable: assert property (p_stable) else $error("readdata moved");
    property p_unmap; rd_ok && idx[7:6] == 2'h0 |-> o_avs_readdata == 32'h0000_0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_mask; wr_ok && idx == adcsw_pkg::IDX_IRQ_MASK && i_avs_writedata[1:0] == 2'h0
        |-> ##[1:2] !o_irq; endproperty
    a_mask: assert property (p_mask) else $error("irq after mask off");
    property p_quiet; mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !o_irq; endproperty
    a_quiet: assert property (p_quiet) else $error("irq while masked");
    property p_ctrl; rd_ok && idx == adcsw_pkg::IDX_CTRL
        |-> o_avs_readdata[7:6] == ctrl_q[7:6] && o_avs_readdata[2:0] == ctrl_q[2:0]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
    c_read: cover property (rd_ok);
    c_irq: cover property ($rose(o_irq));
    c_mask: cover property (wr_ok && idx == adcsw_pkg::IDX_IRQ_MASK);
endmodule
bind adcsw_top adcsw_checker u_adcsw_checker (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq(o_irq)
);

// ===== adcsw_pkg.sv
package adcsw_pkg;
    // ****************************************
    // register indices, byte address = 4 * index
    // ****************************************
    localparam logic [7:0] IDX_RES_LOW = 8'hBD;
    localparam logic [7:0] IDX_RES_HIGH = 8'hBE;
    localparam logic [7:0] IDX_GT_LOW = 8'hC3;
    localparam logic [7:0] IDX_GT_HIGH = 8'hC4;
    localparam logic [7:0] IDX_LT_LOW = 8'hC5;
    localparam logic [7:0] IDX_LT_HIGH = 8'hC6;
    localparam logic [7:0] IDX_CTRL = 8'hE8;
    localparam logic [7:0] IDX_CFG = 8'hE9;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hEA;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hEB;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_GT = 8'hFF;
    localparam logic [7:0] RST_LT = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // ****************************************
    // start source codes
    // ****************************************
    localparam logic [2:0] CM_SOFT = 3'h0;
    localparam logic [2:0] CM_TMR0 = 3'h1;
    localparam logic [2:0] CM_TMR2 = 3'h2;
    localparam logic [2:0] CM_EXT = 3'h4;
    // ****************************************
    // irq bit positions, config bit
    // ****************************************
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WIN = 1;
    localparam int CFG_LJUST = 0;
    // ****************************************
    // timing, in sar clocks = system clocks
    // ****************************************
    localparam int TRACK_CYCLES = 3;
    localparam int CONV_CYCLES = 16;
    localparam int SAMPLE_W = 10;
    localparam int WORD_W = 16;

    typedef struct packed {
        logic en;
        logic track_delay;
        logic conv_done_flag;
        logic conv_busy_flag;
        logic window_hit_flag;
        logic [2:0] conv_start_select;
    } adcsw_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } adcsw_limit_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRACK,
        ST_CONV
    } adcsw_state_t;
endpackage

// ===== adcsw_top.sv
`timescale 1ns/1ps
// Contract
// - busy flag reads 1 during a conversion, 0 otherwise.
// - writing busy 1 starts only with select 000; writing 0 does nothing.
// - in software mode the busy write is the start trigger.
// - select 001 starts on timer 0 overflow, 010 on timer 2.
// - one select code starts on a rising edge of the external pin.
// - window flag sets on a match and stays until cleared.
// - detector compares each result with the limits without software.
// - window flag can be polled or used as an interrupt.
// - limits are greater-than and less-than pairs of high and low bytes.
// - inside or outside sense comes only from the limit ordering.
// - greater-than high byte is read-write, resets to all ones.
// - external start (code 100) skips the extra tracking delay.
// - lt above gt means strictly between; otherwise outside the range.
// - done flag sets on each completed conversion until cleared.
module adcsw_top #(
    parameter int TRACK_CYCLES = adcsw_pkg::TRACK_CYCLES,
    parameter int CONV_CYCLES = adcsw_pkg::CONV_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [adcsw_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [adcsw_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [adcsw_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [7:0] i_tmr_ovf,
    input wire logic i_external_start_pin,
    input wire logic [adcsw_pkg::SAMPLE_W-1:0] i_sample,
    output logic o_irq
);
    // ****************************************
    // bus slave
    // ****************************************
    logic ack_q;
    logic ack_d;
    logic acc;
    logic wr_fire;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] rsel;
    logic [adcsw_pkg::DATA_W-1:0] rdata_q;
    logic [adcsw_pkg::DATA_W-1:0] rdata_d;

    // one wait cycle per access; data lane 0 only
    assign idx = i_avs_address[adcsw_pkg::ADDR_W-1:2];
    assign wdat = i_avs_writedata[7:0];
    assign acc = (i_avs_read | i_avs_write) & ~ack_q;
    assign o_avs_waitrequest = acc;
    assign wr_fire = i_avs_write & ack_q & i_avs_byteenable[0];
    assign o_avs_readdata = rdata_q;

    // ****************************************
    // register state
    // ****************************************
    adcsw_pkg::adcsw_ctrl_t ctrl_q;
    adcsw_pkg::adcsw_ctrl_t ctrl_d;
    adcsw_pkg::adcsw_limit_t gt_q;
    adcsw_pkg::adcsw_limit_t gt_d;
    adcsw_pkg::adcsw_limit_t lt_q;
    adcsw_pkg::adcsw_limit_t lt_d;
    adcsw_pkg::adcsw_limit_t res_q;
    adcsw_pkg::adcsw_limit_t res_d;
    logic ljust_q;
    logic ljust_d;
    logic [1:0] stat_q;
    logic [1:0] stat_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;

    // ****************************************
    // converter sequencing
    // ****************************************
    adcsw_pkg::adcsw_state_t st_q;
    adcsw_pkg::adcsw_state_t st_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic ext_q;
    logic ext_d;
    logic sel_evt;
    logic start;
    logic finish;
    logic [adcsw_pkg::WORD_W-1:0] word;
    logic [adcsw_pkg::WORD_W-1:0] gtw;
    logic [adcsw_pkg::WORD_W-1:0] ltw;
    logic hit;
    logic wr_ctrl;

    assign wr_ctrl = wr_fire & (idx == adcsw_pkg::IDX_CTRL);

    // start source select
    always_comb begin
        ext_d = i_external_start_pin;
        unique case (ctrl_q.conv_start_select)
            adcsw_pkg::CM_SOFT: begin
                sel_evt = wr_ctrl & wdat[4];
            end
            adcsw_pkg::CM_EXT: begin
                sel_evt = i_external_start_pin & ~ext_q;
            end
            default: begin
                // 001 timer 0, 010 timer 2, others further timers
                sel_evt = i_tmr_ovf[ctrl_q.conv_start_select];
            end
        endcase
    end

    // starts while busy or disabled are dropped, not queued
    assign start = sel_evt & ctrl_q.en & (st_q == adcsw_pkg::ST_IDLE);
    assign finish = (st_q == adcsw_pkg::ST_CONV) & (cnt_q == 16'h0000);

    // sample formatted in the current justification
    always_comb begin
        if (ljust_q) begin
            word = {i_sample, 6'h00};
        end else begin
            word = {6'h00, i_sample};
        end
    end

    // limit words high:low
    assign gtw = gt_q;
    assign ltw = lt_q;

    // sense set purely by limit ordering
    always_comb begin
        if (ltw > gtw) begin
            hit = (word > gtw) & (word < ltw);
        end else begin
            hit = (word > gtw) | (word < ltw);
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            adcsw_pkg::ST_IDLE: begin
                if (start) begin
                    // external pin start has no tracking delay
                    if (ctrl_q.track_delay &&
                            ctrl_q.conv_start_select != adcsw_pkg::CM_EXT) begin
                        st_d = adcsw_pkg::ST_TRACK;
                        cnt_d = 16'(TRACK_CYCLES - 1);
                    end else begin
                        st_d = adcsw_pkg::ST_CONV;
                        cnt_d = 16'(CONV_CYCLES - 1);
                    end
                end
            end
            adcsw_pkg::ST_TRACK: begin
                if (cnt_q == 16'h0000) begin
                    st_d = adcsw_pkg::ST_CONV;
                    cnt_d = 16'(CONV_CYCLES - 1);
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            adcsw_pkg::ST_CONV: begin
                if (finish) begin
                    st_d = adcsw_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        endcase
    end

    // ****************************************
    // register next values
    // ****************************************
    always_comb begin
        ctrl_d = ctrl_q;
        gt_d = gt_q;
        lt_d = lt_q;
        res_d = res_q;
        ljust_d = ljust_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_fire) begin
            unique case (idx)
                adcsw_pkg::IDX_GT_HIGH: begin
                    gt_d.high = wdat;
                end
                adcsw_pkg::IDX_GT_LOW: begin
                    gt_d.low = wdat;
                end
                adcsw_pkg::IDX_LT_HIGH: begin
                    lt_d.high = wdat;
                end
                adcsw_pkg::IDX_LT_LOW: begin
                    lt_d.low = wdat;
                end
                adcsw_pkg::IDX_CTRL: begin
                    ctrl_d.en = wdat[7];
                    ctrl_d.track_delay = wdat[6];
                    ctrl_d.conv_start_select = wdat[2:0];
                    // flags clear by writing zero; busy writes only start a conversion in soft mode (select 000)
                    if (!wdat[5]) begin
                        ctrl_d.conv_done_flag = 1'b0;
                    end
                    if (!wdat[3]) begin
                        ctrl_d.window_hit_flag = 1'b0;
                    end
                end
                adcsw_pkg::IDX_CFG: begin
                    ljust_d = wdat[adcsw_pkg::CFG_LJUST];
                end
                adcsw_pkg::IDX_IRQ_STAT: begin
                    if (wdat[adcsw_pkg::IRQ_DONE]) begin
                        ctrl_d.conv_done_flag = 1'b0;
                    end
                    if (wdat[adcsw_pkg::IRQ_WIN]) begin
                        ctrl_d.window_hit_flag = 1'b0;
                    end
                end
                adcsw_pkg::IDX_IRQ_MASK: begin
                    mask_d = wdat[1:0];
                end
                default: begin
                end
            endcase
        end
        if (start) begin
            ctrl_d.conv_busy_flag = 1'b1;
        end
        // sets after clears so a same-cycle event wins
        if (finish) begin
            res_d = word;
            ctrl_d.conv_busy_flag = 1'b0;
            ctrl_d.conv_done_flag = 1'b1;
            if (hit) begin
                ctrl_d.window_hit_flag = 1'b1;
            end
        end
        stat_d[adcsw_pkg::IRQ_DONE] = ctrl_d.conv_done_flag;
        stat_d[adcsw_pkg::IRQ_WIN] = ctrl_d.window_hit_flag;
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rsel = 8'h00;
        unique case (idx)
            adcsw_pkg::IDX_RES_LOW: begin
                rsel = res_q.low;
            end
            adcsw_pkg::IDX_RES_HIGH: begin
                rsel = res_q.high;
            end
            adcsw_pkg::IDX_GT_HIGH: begin
                rsel = gt_q.high;
            end
            adcsw_pkg::IDX_GT_LOW: begin
                rsel = gt_q.low;
            end
            adcsw_pkg::IDX_LT_HIGH: begin
                rsel = lt_q.high;
            end
            adcsw_pkg::IDX_LT_LOW: begin
                rsel = lt_q.low;
            end
            adcsw_pkg::IDX_CTRL: begin
                rsel = ctrl_q;
            end
            adcsw_pkg::IDX_CFG: begin
                rsel = {7'h00, ljust_q};
            end
            adcsw_pkg::IDX_IRQ_STAT: begin
                rsel = {6'h00, stat_q};
            end
            adcsw_pkg::IDX_IRQ_MASK: begin
                rsel = {6'h00, mask_q};
            end
            default: begin
                rsel = 8'h00;
            end
        endcase
        ack_d = acc;
        rdata_d = rdata_q;
        if (acc && i_avs_read) begin
            rdata_d = {24'h00_0000, rsel};
        end
    end

    // status mirrors the flags, so polling and interrupt agree
    assign o_irq = |(stat_q & mask_q);

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            ctrl_q <= adcsw_pkg::RST_CTRL;
            gt_q <= {adcsw_pkg::RST_GT, adcsw_pkg::RST_GT};
            lt_q <= {adcsw_pkg::RST_LT, adcsw_pkg::RST_LT};
            res_q <= '0;
            ljust_q <= 1'b0;
            stat_q <= adcsw_pkg::RST_IRQ;
            mask_q <= adcsw_pkg::RST_IRQ;
            st_q <= adcsw_pkg::ST_IDLE;
            cnt_q <= 16'h0000;
            ext_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            gt_q <= gt_d;
            lt_q <= lt_d;
            res_q <= res_d;
            ljust_q <= ljust_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            ext_q <= ext_d;
        end
    end
endmodule
